// [testbench/msl_host_model.sv]
`timescale 1ns/100ps
// management bus host; address is inverted once the request is released
module msl_host_model
    import msl_pkg::*;
(
    input wire logic clock_i,
    input wire logic [7:0] data_i,
    output msl_host_rd_t rd_o
);
    initial rd_o = '{1'b0, 8'hFF};

    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i) rd_o <= '{1'b1, a};
        @(posedge clock_i) rd_o <= '{1'b0, ~a};
        // data stands until the next read, so one edge later is safe
        @(posedge clock_i) d = data_i;
    endtask : read
endmodule : msl_host_model

// [testbench/msl_status_latch_checker.sv]
`timescale 1ns/100ps
module msl_status_latch_checker
    import msl_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic EVAL_I,
    input wire logic TIMER_MODE_I,
    input wire logic [7:0] OVERTEMP_READING_I,
    input wire logic [7:0] OVERTEMP_THRESHOLD_I,
    input wire logic [15:0] ASSERT_TIME_I,
    input wire logic [15:0] ASSERT_LIMIT_I,
    input wire logic [1:0] DIODE_FAULT_I,
    input wire msl_host_rd_t HOST_RD_I,
    input wire logic [7:0] RD_DATA_O,
    input wire logic ANY_SECONDARY_EVENT_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);
    logic rd_p;
    logic rd_s;
    logic any;
    assign rd_p = HOST_RD_I.rd_strobe && HOST_RD_I.addr == 8'h41;
    assign rd_s = HOST_RD_I.rd_strobe && HOST_RD_I.addr == 8'h42;
    assign any = ANY_SECONDARY_EVENT_O;
    // ****************
    // properties
    // ****************
    property p_hold; !(rd_p || rd_s) |=> $stable(RD_DATA_O); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_por; rd_p |=> RD_DATA_O[7] == $past(any); endproperty
    a_por: assert property (p_por) else $error("summary bit");
    property p_sor; rd_s |=> (|RD_DATA_O) == $past(any); endproperty
    a_sor: assert property (p_sor) else $error("summary out");
    property p_rst; $rose(RST_N_I) |-> RD_DATA_O == 8'h00 && !any; endproperty
    a_rst: assert property (p_rst) else $error("not zero");
    property p_dio; EVAL_I && DIODE_FAULT_I != 2'b00 |=> any; endproperty
    a_dio: assert property (p_dio) else $error("diode lost");
    property p_tmr;
        EVAL_I && TIMER_MODE_I && ASSERT_TIME_I > ASSERT_LIMIT_I |=> any;
    endproperty
    a_tmr: assert property (p_tmr) else $error("timer lost");
    property p_ovt;
        EVAL_I && OVERTEMP_READING_I > OVERTEMP_THRESHOLD_I |=> any;
    endproperty
    a_ovt: assert property (p_ovt) else $error("overtemp lost");
    property p_stay; any && !rd_s |=> any; endproperty
    a_stay: assert property (p_stay) else $error("bit dropped");
    c_sec: cover property (rd_s && any);
    c_ovt: cover property (EVAL_I && OVERTEMP_READING_I > 8'h50);
    c_tmr: cover property (TIMER_MODE_I && $rose(any));
endmodule : msl_status_latch_checker

bind msl_status_latch msl_status_latch_checker i_chk (.CLOCK_I, .RST_N_I,
    .EVAL_I, .TIMER_MODE_I, .OVERTEMP_READING_I, .OVERTEMP_THRESHOLD_I,
    .ASSERT_TIME_I, .ASSERT_LIMIT_I, .DIODE_FAULT_I, .HOST_RD_I,
    .RD_DATA_O, .ANY_SECONDARY_EVENT_O);

// [testbench/testbench.sv]
`timescale 1ns/100ps
module testbench
    import msl_pkg::*;
();
    logic clock = 0;
    logic rst_n = 0;
    logic eval_p = 0, id_mode = 0, timer_mode = 0, wr = 0;
    msl_channel_t [3:0] volt;
    msl_channel_t twelve;
    msl_channel_t [2:0] temp;
    msl_fan_t [3:0] fan;
    logic [7:0] ot_rd = 8'h20, ot_thr = 8'h50, ot_hys = 8'h04;
    logic [5:0] vid = 6'h00;
    logic [15:0] at_time = 16'h0010, at_lim = 16'h0100;
    logic [1:0] diode = 2'b00;
    msl_host_rd_t rd;
    logic [7:0] rdata;
    logic any_ev;
    int n_mismatch = 0;
    int total_checks = 0;

    initial forever #20 clock = ~clock;

    msl_status_latch i_dut (.CLOCK_I(clock), .RST_N_I(rst_n),
        .EVAL_I(eval_p), .VOLT_I(volt), .TWELVE_I(twelve), .TEMP_I(temp),
        .FAN_I(fan), .OVERTEMP_READING_I(ot_rd), .OVERTEMP_THRESHOLD_I(ot_thr),
        .OVERTEMP_HYSTERESIS_I(ot_hys), .ID_MODE_I(id_mode),
        .VOLTAGE_ID_I(vid), .TIMER_MODE_I(timer_mode), .ASSERT_TIME_I(at_time),
        .ASSERT_LIMIT_I(at_lim), .DIODE_FAULT_I(diode), .HOST_RD_I(rd),
        .HOST_WR_I(wr), .RD_DATA_O(rdata), .ANY_SECONDARY_EVENT_O(any_ev));
    msl_host_model i_host (.clock_i(clock), .data_i(rdata), .rd_o(rd));

    task automatic results();
        if (n_mismatch == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    task automatic chk(input logic [7:0] a, e, g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value reg %h expected %h seen %h", a, e, g);
        end
    endtask : chk

    task automatic rc(input logic [7:0] a, e);
        logic [7:0] d;
        i_host.read(a, d);
        chk(a, e, d);
    endtask : rc

    // limits sit at 0x10/0x70: 0x71 and 0x10 violate, 0x70 does not
    task automatic step(input int k, input bit on);
        logic [7:0] v;
        v = on ? ((k % 2) ? 8'h10 : 8'h71) : 8'h70;
        @(posedge clock);
        if (k < 4) volt[k].reading <= v;
        else if (k < 7) temp[k - 4].reading <= v;
        else if (k == 8) twelve.reading <= v;
        else if (k == 9) ot_rd <= on ? 8'h51 : 8'h4B;
        else if (k > 9 && k < 14) fan[k - 10].count <= on ? 16'h1001 : 16'h1000;
        else if (k > 13) diode[k - 14] <= on;
        eval_p <= 1'b1;
        @(posedge clock) eval_p <= 1'b0;
    endtask : step

    task automatic t_bits();
        logic [7:0] a, e;
        for (int k = 0; k < 16; k++) begin
            a = (k < 8) ? 8'h41 : 8'h42;
            e = 8'h01 << (k % 8);
            if (k != 7) repeat (2) begin
                step(k, 1'b1);
                if (k > 7) rc(8'h41, 8'h80);
                rc(a, e);
                @(posedge clock) wr <= 1'b1;
                @(posedge clock) wr <= 1'b0;
                rc(a, e);
                step(k, 1'b0);
                rc(a, e);
                rc(a, 8'h00);
            end
        end
    endtask : t_bits

    task automatic t_spec();
        @(posedge clock);
        fan[0].drive_on <= 1'b0;
        fan[2].drive_on <= 1'b0;
        fan[1].min_limit <= 16'h0000;
        for (int i = 0; i < 4; i++) fan[i].count <= 16'h1001;
        step(7, 1'b0);
        rc(8'h42, 8'h00);
        @(posedge clock) timer_mode <= 1'b1;
        at_time <= 16'h0101;
        step(7, 1'b0);
        @(posedge clock) at_time <= 16'h0100;
        rc(8'h42, 8'h20);
        rc(8'h42, 8'h00);
        step(9, 1'b1);
        @(posedge clock) ot_rd <= 8'h4C;
        rc(8'h42, 8'h02);
        rc(8'h42, 8'h02);
        @(posedge clock) ot_rd <= 8'h4B;
        step(7, 1'b0);
        rc(8'h42, 8'h02);
        rc(8'h42, 8'h00);
        @(posedge clock) id_mode <= 1'b1;
        repeat (600) @(posedge clock);
        vid <= 6'h2A;
        repeat (600) @(posedge clock);
        rc(8'h42, 8'h01);
        rc(8'h42, 8'h00);
    endtask : t_spec

    initial begin
        for (int i = 0; i < 4; i++) begin
            volt[i] = '{8'h40, 8'h10, 8'h70};
            fan[i] = '{16'h0100, 16'h1000, 1'b1, 1'b1};
        end
        temp = volt[2:0];
        twelve = volt[0];
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        rc(8'h41, 8'h00);
        rc(8'h42, 8'h00);
        t_bits();
        t_spec();
        results();
    end

    // the full sequence needs well under 5000 cycles
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        results();
    end
endmodule : testbench

// [verilog/msl_id_change.sv]
`timescale 1ns/100ps
`include "msl_map.svh"

// flags a change of the six id inputs against their value one
// window earlier; samples are taken once per window so a glitch
// shorter than the window may go unseen
module msl_id_change
    import msl_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic enable_i,
    input wire logic [5:0] id_i,
    output logic change_o
);

    localparam int WINDOW = (`MSL_ID_WINDOW_CYCLES < 1) ? 1 :
        `MSL_ID_WINDOW_CYCLES;

    logic [9:0] count;
    logic [5:0] snapshot;
    msl_id_state_t state;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= MSL_ID_IDLE;
            count <= 10'h000;
            snapshot <= 6'h00;
        end else begin
            unique case (state)
                MSL_ID_IDLE: begin
                    if (enable_i) begin
                        snapshot <= id_i;
                        count <= 10'h000;
                        state <= MSL_ID_WAIT;
                    end
                end
                MSL_ID_WAIT: begin
                    if (!enable_i) begin
                        state <= MSL_ID_IDLE;
                    end else if (count == 10'(WINDOW - 1)) begin
                        snapshot <= id_i;
                        count <= 10'h000;
                    end else begin
                        count <= count + 10'h001;
                    end
                end
                default: state <= MSL_ID_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            change_o <= 1'b0;
        end else begin
            change_o <= (state == MSL_ID_WAIT) && enable_i &&
                (count == 10'(WINDOW - 1)) && (id_i != snapshot);
        end
    end

endmodule : msl_id_change

// [verilog/msl_map.svh]
`ifndef MSL_MAP_SVH
`define MSL_MAP_SVH

// register offsets on the management bus
`define MSL_PRIMARY_ADDR 8'h41
`define MSL_SECONDARY_ADDR 8'h42
`define MSL_STATUS_RESET 8'h00

// primary register fields
`define MSL_P_VOLT_LO 0
`define MSL_P_VOLT_HI 3
`define MSL_P_TEMP_LO 4
`define MSL_P_TEMP_HI 6
`define MSL_P_ANY_SEC 7

// secondary register fields
`define MSL_S_TWELVE 0
`define MSL_S_OVERTEMP 1
`define MSL_S_FAN_LO 2
`define MSL_S_FAN_HI 4
`define MSL_S_FAN4 5
`define MSL_S_DIODE1 6
`define MSL_S_DIODE2 7

// tach limit values that disable fault reporting
`define MSL_TACH_ALL_ONES 16'hFFFF
`define MSL_TACH_ALL_ZEROS 16'h0000

// id change look-back window
`define MSL_ID_WINDOW_NS 11000
`define MSL_CLOCK_PERIOD_NS 40
`define MSL_ID_WINDOW_CYCLES (`MSL_ID_WINDOW_NS / `MSL_CLOCK_PERIOD_NS)

`endif

// [verilog/msl_pkg.sv]
package msl_pkg;

    typedef struct packed {
        logic [7:0] reading;
        logic [7:0] low_limit;
        logic [7:0] high_limit;
    } msl_channel_t;

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] min_limit;
        logic drive_on;
        logic valid;
    } msl_fan_t;

    typedef struct packed {
        logic rd_strobe;
        logic [7:0] addr;
    } msl_host_rd_t;

    typedef enum logic [1:0] {
        MSL_ID_IDLE = 2'b01,
        MSL_ID_WAIT = 2'b10
    } msl_id_state_t;

endpackage : msl_pkg

// [verilog/msl_status_latch.sv]
`timescale 1ns/100ps
`include "msl_map.svh"

// Summary of operation
// - voltage limit faults set primary bits 0-3
// - temperature limit faults set primary bits 4-6
// - read clears bit only if fault gone
// - primary bit 7 is OR of secondary
// - secondary bit 0 flags twelve volt fault
// - id mode: bit 0 flags id change
// - overtemperature sets secondary bit 1
// - overtemp clears below threshold minus hysteresis
// - fans one to three set bits 2-4
// - no fan fault while its drive off
// - bit 5 fan four, off with drive three
// - timer mode: bit 5 flags time limit
// - bits 6,7 flag diode faults
// - both registers zero after power-on
// - high is greater, low is at-or-below
// - all-ones or all-zeros tach limit suppresses
module msl_status_latch
    import msl_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic EVAL_I,
    input wire msl_channel_t [3:0] VOLT_I,
    input wire msl_channel_t TWELVE_I,
    input wire msl_channel_t [2:0] TEMP_I,
    input wire msl_fan_t [3:0] FAN_I,
    input wire logic [7:0] OVERTEMP_READING_I,
    input wire logic [7:0] OVERTEMP_THRESHOLD_I,
    input wire logic [7:0] OVERTEMP_HYSTERESIS_I,
    input wire logic ID_MODE_I,
    input wire logic [5:0] VOLTAGE_ID_I,
    input wire logic TIMER_MODE_I,
    input wire logic [15:0] ASSERT_TIME_I,
    input wire logic [15:0] ASSERT_LIMIT_I,
    input wire logic [1:0] DIODE_FAULT_I,
    input wire msl_host_rd_t HOST_RD_I,
    input wire logic HOST_WR_I,
    output logic [7:0] RD_DATA_O,
    output logic ANY_SECONDARY_EVENT_O
);

    // ****************************************************************
    // limit compare helpers
    // ****************************************************************
    function automatic logic out_of_limit(input msl_channel_t ch);
        out_of_limit = (ch.reading > ch.high_limit) ||
            (ch.reading <= ch.low_limit);
    endfunction : out_of_limit

    function automatic logic fan_fault(input msl_fan_t f,
                                       input logic drive_on);
        fan_fault = f.valid && drive_on &&
            (f.min_limit != `MSL_TACH_ALL_ONES) &&
            (f.min_limit != `MSL_TACH_ALL_ZEROS) &&
            (f.count > f.min_limit);
    endfunction : fan_fault

    // ****************************************************************
    // fault conditions
    // ****************************************************************
    logic [7:0] primary_cond;
    logic [7:0] secondary_cond;
    logic id_change;
    logic overtemp_active;
    logic [7:0] overtemp_release;

    msl_id_change u_id_change (
        .clock_i(CLOCK_I),
        .rst_n_i(RST_N_I),
        .enable_i(ID_MODE_I),
        .id_i(VOLTAGE_ID_I),
        .change_o(id_change)
    );

    // release point saturates at zero so a large hysteresis cannot wrap
    assign overtemp_release = (OVERTEMP_HYSTERESIS_I > OVERTEMP_THRESHOLD_I)
        ? 8'h00 : OVERTEMP_THRESHOLD_I - OVERTEMP_HYSTERESIS_I;

    // overtemp condition holds from crossing until below release point
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            overtemp_active <= 1'b0;
        end else if (EVAL_I) begin
            if (OVERTEMP_READING_I > OVERTEMP_THRESHOLD_I) begin
                overtemp_active <= 1'b1;
            end else if (OVERTEMP_READING_I < overtemp_release) begin
                overtemp_active <= 1'b0;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_volt
            assign primary_cond[`MSL_P_VOLT_LO + gi] =
                out_of_limit(VOLT_I[gi]);
        end
        for (gi = 0; gi < 3; gi++) begin : g_temp
            assign primary_cond[`MSL_P_TEMP_LO + gi] =
                out_of_limit(TEMP_I[gi]);
        end
        for (gi = 0; gi < 3; gi++) begin : g_fan
            assign secondary_cond[`MSL_S_FAN_LO + gi] =
                fan_fault(FAN_I[gi], FAN_I[gi].drive_on);
        end
    endgenerate
    assign primary_cond[`MSL_P_ANY_SEC] = 1'b0;

    // id change is an event, not a level, so a read clears it unless a new change arrives in that cycle
    assign secondary_cond[`MSL_S_TWELVE] = ID_MODE_I ? id_change :
        out_of_limit(TWELVE_I);
    // the crossing itself counts too: the held flag only turns on at the
    // same evaluation edge, one cycle too late to be latched by that pulse
    assign secondary_cond[`MSL_S_OVERTEMP] = overtemp_active |
        (OVERTEMP_READING_I > OVERTEMP_THRESHOLD_I);
    assign secondary_cond[`MSL_S_FAN4] = TIMER_MODE_I ?
        (ASSERT_TIME_I > ASSERT_LIMIT_I) :
        fan_fault(FAN_I[3], FAN_I[2].drive_on);
    assign secondary_cond[`MSL_S_DIODE1] = DIODE_FAULT_I[0];
    assign secondary_cond[`MSL_S_DIODE2] = DIODE_FAULT_I[1];

    // ****************************************************************
    // latched status
    // ****************************************************************
    logic [6:0] primary_event_status;
    logic [7:0] secondary_event_status;
    logic [7:0] primary_set;
    logic [7:0] secondary_set;
    logic rd_primary;
    logic rd_secondary;

    // conditions count only at an evaluation point, except an id change, which sets secondary bit 0 on any cycle
    assign primary_set = EVAL_I ? primary_cond : 8'h00;
    assign secondary_set = EVAL_I ? secondary_cond :
        {7'h00, ID_MODE_I & id_change};
    assign rd_primary = HOST_RD_I.rd_strobe &&
        (HOST_RD_I.addr == `MSL_PRIMARY_ADDR);
    assign rd_secondary = HOST_RD_I.rd_strobe &&
        (HOST_RD_I.addr == `MSL_SECONDARY_ADDR);

    // a write strobe has no path into the latches
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            primary_event_status <= 7'(`MSL_STATUS_RESET);
        end else if (rd_primary) begin
            // set wins over clear; persisting faults stay set
            primary_event_status <= primary_set[6:0] |
                primary_cond[6:0];
        end else begin
            primary_event_status <= primary_event_status |
                primary_set[6:0];
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            secondary_event_status <= `MSL_STATUS_RESET;
        end else if (rd_secondary) begin
            secondary_event_status <= secondary_set |
                (secondary_cond & 8'hFE) |
                {7'h00, ~ID_MODE_I & secondary_cond[0]};
        end else begin
            secondary_event_status <= secondary_event_status |
                secondary_set;
        end
    end

    assign ANY_SECONDARY_EVENT_O = |secondary_event_status;

    // ****************************************************************
    // read data
    // ****************************************************************
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RD_DATA_O <= `MSL_STATUS_RESET;
        end else if (rd_primary) begin
            RD_DATA_O <= {|secondary_event_status,
                primary_event_status};
        end else if (rd_secondary) begin
            RD_DATA_O <= secondary_event_status;
        end
    end

endmodule : msl_status_latch
